// [inc/gaac_map.svh]
`ifndef GAAC_MAP_SVH
`define GAAC_MAP_SVH
// Register offsets
`define GAAC_OFS_AMP_MODE     8'h90
`define GAAC_OFS_AMP_CHAN     8'h91
`define GAAC_OFS_CHOP_SEL     8'h92
`define GAAC_OFS_CONV_MODE    8'h93
`define GAAC_OFS_CONV_DIV     8'h94
`define GAAC_OFS_FILTER_MODE  8'h97
`define GAAC_OFS_RESULT_LO    8'h98
`define GAAC_OFS_RESULT_HI    8'h99
// Reset values
`define GAAC_RST_AMP_MODE     8'h3E
`define GAAC_RST_AMP_CHAN     4'h0
`define GAAC_RST_CHOP_SEL     3'h0
`define GAAC_RST_CONV_MODE    4'h0
`define GAAC_RST_CONV_DIV     8'h00
// Amplifier mode fields
`define GAAC_AMP_EN_BIT       0
`define GAAC_GAIN_LSB         1
`define GAAC_CHOP_LF_LSB      4
`define GAAC_BANDGAP_BIT      6
// Converter mode fields
`define GAAC_CONV_EN_BIT      0
`define GAAC_REF_SEL_LSB      1
`define GAAC_SPAN_BIT         3
`define GAAC_RSVD_BIT         4
// Filter mode fields
`define GAAC_DATA_READY_FLAG_BIT         0
`define GAAC_WRS_BIT          2
// Codes
`define GAAC_GAIN_UNITY       3'h7
`define GAAC_CHAN_DIFF        4'h0
`define GAAC_CHAN_SHORT       4'h6
`define GAAC_REF_EXT          2'h0
`define GAAC_REF_INT          2'h2
// Timing counts and result full scale
`define GAAC_CHOP_PREDIV      32
`define GAAC_WORD_CLOCKS      4000
`define GAAC_FULL_SCALE       16'h7A12
`endif

// [inc/gaac_pkg.sv]
package gaac_pkg;
   typedef enum logic [2:0] {
      GAAC_GAIN_12P5 = 3'h0,
      GAAC_GAIN_50   = 3'h1,
      GAAC_GAIN_100  = 3'h2,
      GAAC_GAIN_200  = 3'h3,
      GAAC_GAIN_1    = 3'h7
   } gaac_gain_t;
   typedef enum logic [2:0] {
      GAAC_S_IDLE = 3'b001,
      GAAC_S_RUN  = 3'b010,
      GAAC_S_DONE = 3'b100
   } gaac_state_t;
endpackage

// [inc/gaac_clk_if.sv]
`timescale 1ns/10ps
// Enable-pulse clock bundle between the top and its converter clock divider
interface gaac_clk_if;
   logic       run;
   logic [7:0] div_value;
   logic       tick;
   modport ctrl (output run, output div_value, input tick);
   modport gen  (input run, input div_value, output tick);
endinterface

// [hdl/gaac_divider.sv]
`timescale 1ns/10ps
// Programmable enable divider: a tick every (limit+1)*2 cycles
module gaac_divider
   import gaac_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Control bundle
   gaac_clk_if.gen   bus
);
   logic [7:0] cnt_reg;
   logic       half_reg;

   // Counter clears while stopped so restarts are phase-clean
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 8'h00;
         half_reg <= 1'b0;
         bus.tick <= 1'b0;
      end else begin
         bus.tick <= 1'b0;
         if (!bus.run) begin
            cnt_reg  <= 8'h00;
            half_reg <= 1'b0;
         end else if (cnt_reg >= bus.div_value) begin
            cnt_reg  <= 8'h00;
            half_reg <= ~half_reg;
            bus.tick <= half_reg;
         end else begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
endmodule

// [hdl/gaac_chopper.sv]
`timescale 1ns/10ps
`include "gaac_map.svh"
// Chopper clock: clock / 32 / 2^sel as a square wave
module gaac_chopper
   import gaac_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Control
   input  wire logic [2:0] sel,
   output logic            chop_clk
);
   logic [11:0] cnt_reg;
   logic [11:0] half_period;

   // Half period in cycles
   assign half_period = 12'(`GAAC_CHOP_PREDIV / 2) << sel;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 12'h000;
         chop_clk <= 1'b0;
      end else if (cnt_reg >= half_period - 12'h001) begin
         cnt_reg  <= 12'h000;
         chop_clk <= ~chop_clk;
      end else begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end
endmodule

// [hdl/gaac_top.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "gaac_map.svh"
// Summary of operation
// - Amp mode bit 0 enables amplifier; resets to 0.
// - Gain field bits 3:1 selects 12.5/50/100/200/1; resets to 111.
// - Amp mode bit 6 enables band-gap; set before analog use.
// - At 1x gain the path works even with amplifier disabled.
// - Chopper clock is clock/32/2^select; write-only, resets 0.
// - Channel 0000 routes differential pair, 0110 shorts inputs.
// - Converter mode bit 0 enables converter; resets to 0.
// - Reference field 00 picks external pins, 10 internal.
// - Span bit picks small or doubled internal reference span.
// - Result is 16-bit two's complement, diff/span times 31250.
// - Converter clock is clock/(256-divider)/2; write-only, reset 0.
// - Data-ready sets on each new result; software clears it.
// - Word rate is converter clock/4000, halved when bit set.
// - Result readable as low and high read-only bytes, reset 0.
module gaac_top
   import gaac_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   // Modulator side
   input  wire logic        mod_result_valid,
   input  wire logic [15:0] mod_result,
   // Analog controls
   output logic             amp_power_on,
   output logic      [2:0]  gain_select,
   output logic             amp_bypass,
   output logic      [1:0]  chopper_low_freq_setting,
   output logic             bandgap_enable,
   output logic             chopper_clock,
   output logic             input_route_diff,
   output logic             input_route_short,
   output logic             converter_enable,
   output logic             reference_external,
   output logic             reference_internal,
   output logic             internal_reference_span,
   output logic             converter_clock_tick,
   output logic             word_tick
);
   logic [7:0]  amp_mode_reg;
   logic [3:0]  amp_channel_select_reg;
   logic [2:0]  chopper_clock_select_reg;
   logic [3:0]  converter_mode_reg;
   logic [7:0]  converter_clock_divider_reg;
   logic        data_ready_flag_reg;
   logic        word_rate_select_reg;
   logic [15:0] result_reg;
   logic [12:0] word_cnt_reg;
   logic        word_half_reg;
   gaac_state_t state_reg;
   logic        wr_amp;
   logic        wr_chan;
   logic        wr_chop;
   logic        wr_conv;
   logic        wr_div;
   logic        wr_filt;
   logic        new_result;
   logic        chop_raw;
   logic [15:0] capped;
   gaac_clk_if  conv_clk ();

   // Address decode
   assign wr_amp  = wr && (addr == `GAAC_OFS_AMP_MODE);
   assign wr_chan = wr && (addr == `GAAC_OFS_AMP_CHAN);
   assign wr_chop = wr && (addr == `GAAC_OFS_CHOP_SEL);
   assign wr_conv = wr && (addr == `GAAC_OFS_CONV_MODE);
   assign wr_div  = wr && (addr == `GAAC_OFS_CONV_DIV);
   assign wr_filt = wr && (addr == `GAAC_OFS_FILTER_MODE);

   // Amplifier mode register; bit 7 unimplemented
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         amp_mode_reg <= `GAAC_RST_AMP_MODE;
      end else if (wr_amp) begin
         amp_mode_reg <= {1'b0, wdata[6:0]};
      end
   end

   // Channel, chopper and converter setup registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         amp_channel_select_reg      <= `GAAC_RST_AMP_CHAN;
         chopper_clock_select_reg    <= `GAAC_RST_CHOP_SEL;
         converter_mode_reg          <= `GAAC_RST_CONV_MODE;
         converter_clock_divider_reg <= `GAAC_RST_CONV_DIV;
      end else begin
         if (wr_chan)
            amp_channel_select_reg <= wdata[3:0];
         if (wr_chop)
            chopper_clock_select_reg <= wdata[2:0];
         if (wr_conv)
            converter_mode_reg <= wdata[3:0];
         if (wr_div)
            converter_clock_divider_reg <= wdata;
      end
   end

   // Word rate select, software writable
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         word_rate_select_reg <= 1'b0;
      end else if (wr_filt) begin
         word_rate_select_reg <= wdata[`GAAC_WRS_BIT];
      end
   end

   // Converter clock divider runs only while converter enabled
   assign conv_clk.run = converter_mode_reg[`GAAC_CONV_EN_BIT];
   // Count limit 255-div gives (256-div) cycles per half
   assign conv_clk.div_value = 8'hFF - converter_clock_divider_reg;

   gaac_divider u_conv_div (
      .clock (clock),
      .rst_n (rst_n),
      .bus   (conv_clk.gen)
   );

   gaac_chopper u_chop (
      .clock    (clock),
      .rst_n    (rst_n),
      .sel      (chopper_clock_select_reg),
      .chop_clk (chop_raw)
   );

   // Word-rate sequencer over converter clock ticks
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= GAAC_S_IDLE;
         word_cnt_reg  <= 13'h0000;
         word_half_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            GAAC_S_IDLE: begin
               word_cnt_reg  <= 13'h0000;
               word_half_reg <= 1'b0;
               if (conv_clk.run)
                  state_reg <= GAAC_S_RUN;
            end
            GAAC_S_RUN: begin
               if (!conv_clk.run) begin
                  state_reg <= GAAC_S_IDLE;
               end else if (conv_clk.tick) begin
                  if (word_cnt_reg == 13'(`GAAC_WORD_CLOCKS - 1)) begin
                     word_cnt_reg <= 13'h0000;
                     // Half rate: only every second word is posted
                     word_half_reg <= ~word_half_reg;
                     if (!word_rate_select_reg || word_half_reg)
                        state_reg <= GAAC_S_DONE;
                  end else begin
                     word_cnt_reg <= word_cnt_reg + 13'h0001;
                  end
               end
            end
            GAAC_S_DONE: begin
               word_half_reg <= 1'b0;
               state_reg <= conv_clk.run ? GAAC_S_RUN : GAAC_S_IDLE;
            end
         endcase
      end
   end

   assign new_result = (state_reg == GAAC_S_DONE) && conv_clk.run;

   // Clamp modulator sample to documented full scale
   always_comb begin
      capped = mod_result;
      if (!mod_result[15] && mod_result > `GAAC_FULL_SCALE)
         capped = `GAAC_FULL_SCALE;
      else if (mod_result[15] && mod_result < (16'h0000 - `GAAC_FULL_SCALE))
         capped = 16'h0000 - `GAAC_FULL_SCALE;
   end

   // Result latch; last modulator word held at word boundary
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result_reg <= 16'h0000;
      end else if (new_result && mod_result_valid) begin
         result_reg <= capped;
      end
   end

   // Data-ready: a new result beats a same-cycle software clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         data_ready_flag_reg <= 1'b0;
      end else if (new_result && mod_result_valid) begin
         data_ready_flag_reg <= 1'b1;
      end else if (wr_filt && !wdata[`GAAC_DATA_READY_FLAG_BIT]) begin
         data_ready_flag_reg <= 1'b0;
      end
   end

   // Read mux; write-only and unmapped addresses read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            `GAAC_OFS_AMP_MODE:    rdata <= amp_mode_reg;
            `GAAC_OFS_AMP_CHAN:    rdata <= {4'h0, amp_channel_select_reg};
            `GAAC_OFS_CONV_MODE:   rdata <= {4'h0, converter_mode_reg};
            `GAAC_OFS_FILTER_MODE: rdata <= {5'h00, word_rate_select_reg,
                                             1'b0, data_ready_flag_reg};
            `GAAC_OFS_RESULT_LO:   rdata <= result_reg[7:0];
            `GAAC_OFS_RESULT_HI:   rdata <= result_reg[15:8];
            default:               rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Registered analog controls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         amp_power_on             <= 1'b0;
         gain_select              <= `GAAC_GAIN_UNITY;
         amp_bypass               <= 1'b0;
         chopper_low_freq_setting <= 2'h3;
         bandgap_enable           <= 1'b0;
         chopper_clock            <= 1'b0;
         input_route_diff         <= 1'b0;
         input_route_short        <= 1'b0;
         converter_enable         <= 1'b0;
         reference_external       <= 1'b0;
         reference_internal       <= 1'b0;
         internal_reference_span  <= 1'b0;
         converter_clock_tick     <= 1'b0;
         word_tick                <= 1'b0;
      end else begin
         amp_power_on <= amp_mode_reg[`GAAC_AMP_EN_BIT];
         gain_select  <= amp_mode_reg[`GAAC_GAIN_LSB +: 3];
         // Unity gain with amp off passes the signal straight through
         amp_bypass <= !amp_mode_reg[`GAAC_AMP_EN_BIT] &&
            (amp_mode_reg[`GAAC_GAIN_LSB +: 3] == `GAAC_GAIN_UNITY);
         chopper_low_freq_setting <= amp_mode_reg[`GAAC_CHOP_LF_LSB +: 2];
         bandgap_enable <= amp_mode_reg[`GAAC_BANDGAP_BIT];
         chopper_clock  <= chop_raw;
         input_route_diff  <= amp_channel_select_reg == `GAAC_CHAN_DIFF;
         input_route_short <= amp_channel_select_reg == `GAAC_CHAN_SHORT;
         converter_enable  <= converter_mode_reg[`GAAC_CONV_EN_BIT];
         reference_external <= converter_mode_reg[`GAAC_REF_SEL_LSB +: 2]
                               == `GAAC_REF_EXT;
         reference_internal <= converter_mode_reg[`GAAC_REF_SEL_LSB +: 2]
                               == `GAAC_REF_INT;
         internal_reference_span <= converter_mode_reg[`GAAC_SPAN_BIT];
         // Gate with run so no tick outlives the enable it belongs to
         converter_clock_tick <= conv_clk.tick && conv_clk.run;
         word_tick <= new_result;
      end
   end
endmodule

// [verification/gaac_props.sv]
`timescale 1ns/10ps
// Port checks on the converter control block
module gaac_props (
   // Clock and reset
   input wire logic       clock,
   input wire logic       rst_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // Analog controls
   input wire logic       amp_power_on,
   input wire logic [2:0] gain_select,
   input wire logic       amp_bypass,
   input wire logic       input_route_diff,
   input wire logic       input_route_short,
   input wire logic       converter_enable,
   input wire logic       reference_external,
   input wire logic       reference_internal,
   input wire logic       converter_clock_tick,
   input wire logic       word_tick
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Read data only in the cycle after a read
   a_rdata_quiet: assert property (
      !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
   a_wo_read: assert property (
      rd && (addr == 8'h92 || addr == 8'h94) |=> rdata == 8'h00)
      else $error("write-only place read nonzero");
   a_unmapped_read: assert property (
      rd && addr > 8'h99 |=> rdata == 8'h00)
      else $error("unmapped read nonzero");
   // Skip first edge: outputs still hold their reset image
   a_bypass_unity: assert property (
      $past(rst_n) |-> amp_bypass == (!amp_power_on && gain_select == 3'h7))
      else $error("bypass wrong");
   a_route_excl: assert property (
      !(input_route_diff && input_route_short)) else $error("two routes");
   a_ref_excl: assert property (
      !(reference_external && reference_internal))
      else $error("two references");
   a_tick_enabled: assert property (
      converter_clock_tick || word_tick |-> converter_enable)
      else $error("tick while disabled");
   a_tick_spacing: assert property (
      converter_clock_tick |=> !converter_clock_tick)
      else $error("ticks too close");
endmodule

bind gaac_top gaac_props gaac_props_i (
   .clock(clock), .rst_n(rst_n), .addr(addr), .rd(rd), .rdata(rdata),
   .amp_power_on(amp_power_on), .gain_select(gain_select),
   .amp_bypass(amp_bypass), .input_route_diff(input_route_diff),
   .input_route_short(input_route_short),
   .converter_enable(converter_enable),
   .reference_external(reference_external),
   .reference_internal(reference_internal),
   .converter_clock_tick(converter_clock_tick), .word_tick(word_tick));

// [verification/gaac_mod_model.sv]
`timescale 1ns/10ps
// Behavioural modulator presenting a word level
module gaac_mod_model (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Bench controls
   input  wire logic        valid_en,
   input  wire logic [15:0] word,
   // Control block side
   output logic             mod_result_valid,
   output logic [15:0]      mod_result
);
   // Invalid word flips each cycle so stale data never looks good
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mod_result_valid <= 1'b0;
         mod_result       <= 16'h0000;
      end else begin
         mod_result_valid <= valid_en;
         mod_result       <= valid_en ? word : ~mod_result;
      end
   end
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
   // Bench signals
   logic        clock, rst_n, wr, rd, m_valid, mv, apo, byp, bg, chp;
   logic        rdf, rsh, cen, rex, rin, spn, ctk, wtk;
   logic [1:0]  lf;
   logic [2:0]  gs;
   logic [7:0]  addr, wdata, rdata;
   logic [15:0] m_word, mres;
   logic [2:0]  gains [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3};
   logic [7:0]  ra [9] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h97,
                           8'h98, 8'h99, 8'hA5};
   int          err_count, n_compared, per, i;

   gaac_top gaac_top_i (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .mod_result_valid(mv), .mod_result(mres), .amp_power_on(apo),
      .gain_select(gs), .amp_bypass(byp), .chopper_low_freq_setting(lf),
      .bandgap_enable(bg), .chopper_clock(chp), .input_route_diff(rdf),
      .input_route_short(rsh), .converter_enable(cen),
      .reference_external(rex), .reference_internal(rin),
      .internal_reference_span(spn), .converter_clock_tick(ctk),
      .word_tick(wtk));
   gaac_mod_model gaac_mod_model_i (.clock(clock), .rst_n(rst_n),
      .valid_en(m_valid), .word(m_word), .mod_result_valid(mv),
      .mod_result(mres));

   // 50 MHz clock
   always #10 clock = ~clock;

   task chk(input string name, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr_reg(input logic [7:0] a, d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, exp);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk("rdata", 16'(rdata), 16'(exp));
   endtask
   // Outputs lag their register by a clock
   task settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   function logic sig(input int s);
      return s == 0 ? chp : (s == 1 ? ctk : wtk);
   endfunction
   // Cycles between two rising edges of a watched output
   task gap(input int s, output int n);
      int  j, c;
      logic p, v;
      c = -1;
      p = 1'b1;
      n = 0;
      for (j = 0; j < 40000 && n == 0; j++) begin
         @(posedge clock);
         #1;
         v = sig(s);
         if (c >= 0) c++;
         if (v && !p) begin
            if (c > 0) n = c;
            else c = 0;
         end
         p = v;
      end
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog well past the longest expected run
   initial begin
      repeat (90000) @(posedge clock);
      err_count++;
      finish_test;
   end

   // Main sequence
   initial begin
      clock = 0; rst_n = 0; wr = 0; rd = 0; addr = 0; wdata = 0;
      m_valid = 1; m_word = 16'h8000; err_count = 0; n_compared = 0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      settle;
      chk("gain", 16'(gs), 16'h0007);
      chk("lowfreq", 16'(lf), 16'h0003);
      chk("amp_on", 16'(apo), 16'h0000);
      chk("bandgap", 16'(bg), 16'h0000);
      chk("diff", 16'(rdf), 16'h0001);
      for (i = 0; i < 9; i++) rd_chk(ra[i], i == 0 ? 8'h3E : 8'h00);
      // Every gain code; band-gap always on whenever the amplifier runs
      for (i = 0; i < 5; i++) begin
         wr_reg(8'h90, {1'b1, ~i[0], 2'b11, gains[i], ~i[0]});
         settle;
         chk("gain", 16'(gs), 16'(gains[i]));
         chk("amp_on", 16'(apo), 16'(!i[0]));
         chk("bandgap", 16'(bg), 16'(!i[0]));
         chk("bypass", 16'(byp), 16'(i[0] && gains[i] == 3'h7));
         rd_chk(8'h90, {1'b0, ~i[0], 2'b11, gains[i], ~i[0]});
      end
      // Input short then back to differential
      wr_reg(8'h91, 8'h06);
      settle;
      chk("short", 16'({rsh, rdf}), 16'h0002);
      rd_chk(8'h91, 8'h06);
      wr_reg(8'h91, 8'h00);
      settle;
      chk("diff", 16'({rsh, rdf}), 16'h0001);
      // Internal reference with doubled span, then external
      wr_reg(8'h93, 8'h0C);
      settle;
      chk("ref_int", 16'({rin, rex, spn, cen}), 16'h000A);
      rd_chk(8'h93, 8'h0C);
      wr_reg(8'h93, 8'h00);
      settle;
      chk("ref_ext", 16'({rin, rex, spn}), 16'h0002);
      // Chopper period doubles per select step
      for (i = 0; i < 3; i++) begin
         wr_reg(8'h92, 8'(i));
         gap(0, per);
         gap(0, per);
         chk("chop", 16'(per), 16'(32 << i));
      end
      // Converter clock for two divider values
      wr_reg(8'h94, 8'hFE);
      wr_reg(8'h93, 8'h01);
      gap(1, per);
      chk("conv_clk", 16'(per), 16'h0004);
      wr_reg(8'h94, 8'hFF);
      gap(1, per);
      gap(1, per);
      chk("conv_clk", 16'(per), 16'h0002);
      // Word rate, data-ready and result bytes
      gap(2, per);
      chk("word", 16'(per), 16'd8000);
      rd_chk(8'h97, 8'h01);
      rd_chk(8'h98, 8'hEE);
      rd_chk(8'h99, 8'h85);
      wr_reg(8'h97, 8'h00);
      rd_chk(8'h97, 8'h00);
      // Half word rate; a positive over-range word must clamp to full scale
      m_word <= 16'h7FFF;
      wr_reg(8'h97, 8'h04);
      gap(2, per);
      chk("word", 16'(per), 16'd16000);
      rd_chk(8'h97, 8'h05);
      rd_chk(8'h98, 8'h12);
      rd_chk(8'h99, 8'h7A);
      // Disabled converter posts nothing
      wr_reg(8'h93, 8'h00);
      wr_reg(8'h97, 8'h00);
      repeat (9000) @(posedge clock);
      rd_chk(8'h97, 8'h00);
      finish_test;
   end
endmodule
